// ===== hw/sid_delay_line.sv
// Programmable delay line for one sync strobe, tap chosen from 0 to DEPTH clocks.
// Assumes the strobe input is already synchronous to clk.
`default_nettype none

module sid_delay_line
	import sid_pkg::*;
#(
	parameter int DEPTH = SID_MAX_DELAY
) (
	input wire logic clk,
	input wire logic rst_b,
	sid_strobe_if.line link
);

	logic [DEPTH-1:0] hist_reg;
	logic [DEPTH-1:0] hist_next;

	// ****************************************
	// History shift and tap select
	// ****************************************
	// Tap is combinational so a delay of zero costs nothing here; the top registers it
	always_comb begin
		hist_next = {hist_reg[DEPTH-2:0], link.strobeIn};
		if (link.delaySel == '0) begin
			link.strobeTap = link.strobeIn;
		end else begin
			link.strobeTap = hist_reg[link.delaySel - 1'b1]; // RL1 RL2
		end
	end

	// History registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hist_reg <= '0;
		end else begin
			hist_reg <= hist_next;
		end
	end

endmodule

`default_nettype wire

// ===== hw/sid_pkg.sv
// Constants, field layout and phase type for the sync input delay and identification block.
// Assumes a single 250 MHz system clock and byte-wide 4:2:2 pixel data at one sample per clock.
//
// Operation
// (RL1) The horizontal sync strobe is delayed by 0 to 7 system clocks, as set by the horizontal delay field.
// (RL2) The vertical sync strobe is delayed by 0 to 7 system clocks, as set by the vertical delay field.
// (RL3) With the chroma swap bit set, the blue- and red-difference slots are exchanged, otherwise order is kept.
// (RL4) After reset every field of the input timing control register reads zero.
// (RL5) The low six bits of the read-only identification register hold a fixed part code that writes cannot change.
// (RL6) The top two bits of the identification register hold a read-only revision code.
// (RL7) The revision code changes only for silicon changes that need different host software.
// (RL8) Delayed sync strobes drive line and field timing only while separate strobes, not embedded codes, are selected.
// (RL9) The host writes zero to the reserved top control bit and does not rely on its read value.
// (RL10) A new delay or swap setting takes effect on the first clock after its write, disturbing nothing else.
`default_nettype none

package sid_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] SID_ADDR_CTRL = 8'h04;
	localparam logic [7:0] SID_ADDR_ID = 8'h05;
	localparam logic [7:0] SID_CTRL_RESET = 8'h00;
	localparam logic [7:0] SID_READ_UNMAPPED = 8'h00;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int SID_DELAY_W = 3;
	localparam int SID_HDLY_LSB = 0;
	localparam int SID_VDLY_LSB = 3;
	localparam int SID_SWAP_BIT = 6;
	localparam int SID_PART_W = 6;
	localparam int SID_REV_W = 2;
	localparam int SID_MAX_DELAY = 7;

	// Sample slot of the multiplexed 4:2:2 stream
	typedef enum logic [1:0] {
		SID_PH_CB,
		SID_PH_Y0,
		SID_PH_CR,
		SID_PH_Y1
	} sid_phase_t;

endpackage

`default_nettype wire

// ===== hw/sid_strobe_if.sv
// Carrier between the top module and one sync delay line.
// Assumes both ends run on the same system clock.
`default_nettype none

interface sid_strobe_if;
	import sid_pkg::*;
	logic strobeIn;
	logic [SID_DELAY_W-1:0] delaySel;
	logic strobeTap;

	modport feed (output strobeIn, output delaySel, input strobeTap);
	modport line (input strobeIn, input delaySel, output strobeTap);
endinterface

`default_nettype wire

// ===== hw/sid_sync_input.sv
// Input stage control: sync delay, chroma slot swap and identification register.
// Assumes a host-side register port (sub address, write strobe, data) and synchronous sync and pixel inputs.
`default_nettype none

module sid_sync_input
	import sid_pkg::*;
#(
	parameter logic [SID_PART_W-1:0] PART_CODE = 6'h2A, // Arbitrary value
	parameter logic [SID_REV_W-1:0] REV_CODE = 2'h1 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	input wire logic embeddedSyncSelect,
	input wire logic [7:0] pixIn,
	output logic [7:0] pixOut,
	output logic lineStrobe,
	output logic fieldStrobe
);

	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] rdata_reg, rdata_next;
	logic line_reg, line_next, field_reg, field_next;
	logic hTap_reg, hTap_next;
	sid_phase_t phase_reg, phase_next, phD1_reg, phD1_next, phD2_reg, phD2_next;
	logic [7:0] pixD1_reg, pixD1_next, pixD2_reg, pixD2_next;
	logic [7:0] pixD3_reg, pixD3_next, pixD4_reg, pixD4_next;
	logic [7:0] pix_reg, pix_next;
	logic hEdge, swapOn;

	sid_strobe_if hLink();
	sid_strobe_if vLink();

	// ****************************************
	// Sync delay lines
	// ****************************************
	assign hLink.strobeIn = hsyncIn;
	assign hLink.delaySel = ctrl_reg[SID_HDLY_LSB +: SID_DELAY_W]; // RL1 RL10
	assign vLink.strobeIn = vsyncIn;
	assign vLink.delaySel = ctrl_reg[SID_VDLY_LSB +: SID_DELAY_W]; // RL2 RL10

	sid_delay_line #(.DEPTH(SID_MAX_DELAY)) uHDelay (.clk(clk), .rst_b(rst_b), .link(hLink.line));
	sid_delay_line #(.DEPTH(SID_MAX_DELAY)) uVDelay (.clk(clk), .rst_b(rst_b), .link(vLink.line));

	// ****************************************
	// Register port
	// ****************************************
	// Read data is registered, so it follows the address by one clock
	always_comb begin
		ctrl_next = ctrl_reg;
		if (regWrite && regAddr == SID_ADDR_CTRL) begin
			ctrl_next = regWdata; // RL10
		end
		// Writes to the identification address fall through untouched
		case (regAddr)
			SID_ADDR_CTRL: rdata_next = ctrl_reg;
			SID_ADDR_ID: rdata_next = {REV_CODE, PART_CODE}; // RL5 RL6 RL7
			default: rdata_next = SID_READ_UNMAPPED;
		endcase
	end

	// Control and read-back registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= SID_CTRL_RESET; // RL4
			rdata_reg <= SID_READ_UNMAPPED;
		end else begin
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// Timing strobes
	// ****************************************
	// Embedded timing codes own the timing, so separate strobes are masked then
	always_comb begin
		line_next = hLink.strobeTap && !embeddedSyncSelect; // RL8
		field_next = vLink.strobeTap && !embeddedSyncSelect; // RL8
		hTap_next = hLink.strobeTap;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_reg <= 1'b0;
			field_reg <= 1'b0;
			hTap_reg <= 1'b0;
		end else begin
			line_reg <= line_next;
			field_reg <= field_next;
			hTap_reg <= hTap_next;
		end
	end

	// ****************************************
	// Chroma slot swap
	// ****************************************
	// Fixed three-clock latency, with the slot chosen two samples back, lets Cr be pulled forward and Cb held back
	assign hEdge = hLink.strobeTap && !hTap_reg;
	assign swapOn = ctrl_reg[SID_SWAP_BIT];

	always_comb begin
		// Leading edge of the delayed strobe marks a Cb sample
		if (hEdge) begin
			phase_next = SID_PH_Y0;
			phD1_next = SID_PH_CB;
		end else begin
			phase_next = sid_phase_t'(phase_reg + 2'h1);
			phD1_next = phase_reg;
		end
		phD2_next = phD1_reg;
		pixD1_next = pixIn;
		pixD2_next = pixD1_reg;
		pixD3_next = pixD2_reg;
		pixD4_next = pixD3_reg;
		pix_next = pixD2_reg;
		if (swapOn) begin
			// Cr of the same group is still at the input; its Cb sits two stages deeper
			case (phD2_reg)
				SID_PH_CB: pix_next = pixIn; // RL3
				SID_PH_CR: pix_next = pixD4_reg; // RL3
				default: pix_next = pixD2_reg;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= SID_PH_CB;
			phD1_reg <= SID_PH_CB;
			phD2_reg <= SID_PH_CB;
			pixD1_reg <= '0;
			pixD2_reg <= '0;
			pixD3_reg <= '0;
			pixD4_reg <= '0;
			pix_reg <= '0;
		end else begin
			phase_reg <= phase_next;
			phD1_reg <= phD1_next;
			phD2_reg <= phD2_next;
			pixD1_reg <= pixD1_next;
			pixD2_reg <= pixD2_next;
			pixD3_reg <= pixD3_next;
			pixD4_reg <= pixD4_next;
			pix_reg <= pix_next;
		end
	end

	assign regRdata = rdata_reg;
	assign pixOut = pix_reg;
	assign lineStrobe = line_reg;
	assign fieldStrobe = field_reg;

	// ****************************************
	// Checks
	// ****************************************
	// Independent history used only to check the delay lines
	// Clocks since reset release, saturating at the warm mark
	// Pixel checks look up to five clocks back, so a sample taken just before
	// a mid-run reset must never be held against the flushed pipeline
	localparam logic [2:0] CHK_WARM = 3'h7;
	logic [SID_MAX_DELAY-1:0] chkH_reg, chkV_reg;
	logic [2:0] runCnt_reg;
	logic chkWarm;
	logic expH, expV;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chkH_reg <= '0;
			chkV_reg <= '0;
			runCnt_reg <= 3'h0;
		end else begin
			chkH_reg <= {chkH_reg[SID_MAX_DELAY-2:0], hsyncIn};
			chkV_reg <= {chkV_reg[SID_MAX_DELAY-2:0], vsyncIn};
			if (runCnt_reg != CHK_WARM) begin
				runCnt_reg <= runCnt_reg + 3'h1;
			end
		end
	end
	// Expected taps and the warm flag
	always_comb begin
		expH = (hLink.delaySel == '0) ? hsyncIn : chkH_reg[hLink.delaySel - 1'b1];
		expV = (vLink.delaySel == '0) ? vsyncIn : chkV_reg[vLink.delaySel - 1'b1];
		chkWarm = (runCnt_reg == CHK_WARM);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_hsync_delay_tap: assert property (!embeddedSyncSelect |=> lineStrobe == $past(expH)) // RL1
		else $error("line strobe does not match delayed hsync");
	a_vsync_delay_tap: assert property (!embeddedSyncSelect |=> fieldStrobe == $past(expV)) // RL2
		else $error("field strobe does not match delayed vsync");
	a_swap_cb_slot: assert property (swapOn && phD2_reg == SID_PH_CB |=> pixOut == $past(pixIn)) // RL3
		else $error("swapped Cb slot does not carry Cr");
	// The Cb of a group entered four clocks before its Cr slot is registered
	a_swap_cr_slot: assert property (chkWarm && swapOn && phD2_reg == SID_PH_CR |=> pixOut == $past(pixIn, 5)) // RL3
		else $error("swapped Cr slot does not carry Cb");
	a_plain_order: assert property (chkWarm && !swapOn |=> pixOut == $past(pixIn, 3)) // RL3
		else $error("unswapped stream is not a three-clock copy");
	a_reset_ctrl_zero: assert property (runCnt_reg == 3'h0 |-> ctrl_reg == SID_CTRL_RESET) // RL4
		else $error("control register not zero after reset");
	a_id_part_code: assert property (regAddr == SID_ADDR_ID |=> regRdata[SID_PART_W-1:0] == PART_CODE) // RL5
		else $error("part code read back wrong");
	a_id_write_ignored: assert property (regWrite && regAddr == SID_ADDR_ID |=> $stable(ctrl_reg)) // RL5
		else $error("write to identification disturbed control");
	a_id_revision: assert property (regAddr == SID_ADDR_ID ##1 regAddr == SID_ADDR_ID |=> 
		regRdata[SID_PART_W+SID_REV_W-1:SID_PART_W] == REV_CODE && $stable(regRdata)) // RL6 RL7
		else $error("revision code read back wrong");
	a_embedded_mask: assert property (embeddedSyncSelect |=> !lineStrobe && !fieldStrobe) // RL8
		else $error("strobe passed while embedded sync selected");
	a_write_applies: assert property (regWrite && regAddr == SID_ADDR_CTRL |=> ctrl_reg == $past(regWdata)) // RL10
		else $error("control write not applied next clock");

	// Main scenarios the bench is expected to reach
	c_swap_active: cover property (swapOn && phD2_reg == SID_PH_CB);
	c_swap_cr_slot: cover property (swapOn && phD2_reg == SID_PH_CR);
	c_max_delay: cover property (hLink.delaySel == 3'(SID_MAX_DELAY) && lineStrobe);
	c_id_read: cover property (regAddr == SID_ADDR_ID ##1 regRdata[SID_PART_W-1:0] == PART_CODE);
	// A raw strobe arriving while embedded codes own the timing
	c_embedded_mask: cover property (embeddedSyncSelect && hsyncIn);

endmodule

`default_nettype wire

// ===== testbench/sid_video_source.sv
// Video source model: sync strobes and a counting 4:2:2 sample stream.
// Assumes the bench pulses lineGo for one clock to start each line.
`default_nettype none

module sid_video_source (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic lineGo,
	output logic hsyncOut,
	output logic vsyncOut,
	output logic [7:0] pixOut
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Line start and sample stream
	// ****************************************
	// Counting samples make every slot unique, so a misplaced slot cannot hide
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hsyncOut <= 1'h0;
			vsyncOut <= 1'h0;
			pixOut <= 8'h00;
		end else begin
			hsyncOut <= lineGo;
			vsyncOut <= lineGo;
			pixOut <= lineGo ? 8'h00 : pixOut + 8'h01; // Cb slot starts with the strobe
		end
	end
endmodule

`default_nettype wire

// ===== testbench/tb_sync_input_delay_and_id.sv
// Self-checking bench for the sync input delay and identification block.
// Assumes the video source model drives the sync and pixel inputs.
`default_nettype none

module tb_sync_input_delay_and_id import sid_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [SID_PART_W-1:0] PART = 6'h15; // Arbitrary value
	localparam logic [SID_REV_W-1:0] REV = 2'h2; // Arbitrary value
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic regWrite = 1'h0;
	logic [7:0] regWdata = 8'h00;
	logic embSel = 1'h0;
	logic lineGo = 1'h0;
	logic [7:0] hN;
	logic [7:0] vN;
	wire logic [7:0] regRdata;
	wire logic [7:0] pixIn;
	wire logic [7:0] pixOut;
	wire logic hsyncIn;
	wire logic vsyncIn;
	wire logic lineStrobe;
	wire logic fieldStrobe;
	int mismatches = 0;
	int check_count = 0;

	// ****************************************
	// Clock, design and source
	// ****************************************
	initial begin
		forever #2 clk = ~clk;
	end
	sid_sync_input #(.PART_CODE(PART), .REV_CODE(REV)) dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn),
		.embeddedSyncSelect(embSel), .pixIn(pixIn), .pixOut(pixOut), .lineStrobe(lineStrobe),
		.fieldStrobe(fieldStrobe));
	sid_video_source src_u (.clk(clk), .rst_b(rst_b), .lineGo(lineGo), .hsyncOut(hsyncIn), .vsyncOut(vsyncIn),
		.pixOut(pixIn));

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge clk);
		regWrite <= 1'h0;
	endtask
	// Read data is registered, so it is looked at one edge after the address
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		@(posedge clk);
		#1 chk8(regRdata, exp);
	endtask
	// Edges from the raw strobe to each delayed strobe; FF means it never came
	task automatic sync_meas();
		hN = 8'hFF;
		vN = 8'hFF;
		@(posedge clk) lineGo <= 1'h1;
		@(posedge clk) lineGo <= 1'h0;
		for (int i = 1; i < 13; i++) begin
			@(posedge clk);
			#1;
			if (lineStrobe === 1'h1 && hN === 8'hFF) hN = 8'(i);
			if (fieldStrobe === 1'h1 && vN === 8'hFF) vN = 8'(i);
		end
	endtask
	task automatic pix_run(input logic swap);
		wr(SID_ADDR_CTRL, {1'h0, swap, 6'h00});
		@(posedge clk) lineGo <= 1'h1;
		@(posedge clk) lineGo <= 1'h0;
		repeat (3) @(posedge clk);
		for (int j = 0; j < 12; j++) begin
			#1;
			if (swap && j % 4 == 0) chk8(pixOut, 8'(j + 2));
			else if (swap && j % 4 == 2) chk8(pixOut, 8'(j - 2));
			else chk8(pixOut, 8'(j));
			@(posedge clk);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		rd(SID_ADDR_CTRL, SID_CTRL_RESET);
		rd(SID_ADDR_ID, {REV, PART});
		wr(SID_ADDR_ID, 8'hFF);
		rd(SID_ADDR_ID, {REV, PART});
		rd(8'h06, SID_READ_UNMAPPED);
		// Opposite delays on the two strobes catch a swapped field
		for (int d = 0; d < 8; d++) begin
			wr(SID_ADDR_CTRL, {2'h0, 3'(7 - d), 3'(d)});
			sync_meas();
			chk8(hN, 8'(d + 1));
			chk8(vN, 8'(8 - d));
		end
		@(posedge clk) embSel <= 1'h1;
		sync_meas();
		chk8(hN, 8'hFF);
		chk8(vN, 8'hFF);
		@(posedge clk) embSel <= 1'h0;
		pix_run(1'h0);
		pix_run(1'h1);
		wr(SID_ADDR_CTRL, 8'h5D);
		rd(SID_ADDR_CTRL, 8'h5D);
		@(posedge clk) rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		rd(SID_ADDR_CTRL, SID_CTRL_RESET);
		close_out();
	end
	// Whole run is well under a thousand clocks
	initial begin
		#20000;
		mismatches++;
		close_out();
	end
endmodule

`default_nettype wire
